// [hdl/tls_map.vh]
// Register offsets, field positions and reset values for the limit/status block.
// Assumes a plain Verilog-2005 flow; included by bare name.
`ifndef TLS_MAP_VH
`define TLS_MAP_VH

// Read offsets
`define TLS_RD_LOCAL_VAL     8'h00
`define TLS_RD_REMOTE_VAL_HI 8'h01
`define TLS_RD_STATUS        8'h02
`define TLS_RD_CONFIG        8'h03
`define TLS_RD_LOCAL_HIGH    8'h05
`define TLS_RD_LOCAL_LOW     8'h06
`define TLS_RD_REM_HIGH_HI   8'h07
`define TLS_RD_REM_LOW_HI    8'h08
`define TLS_RD_REMOTE_VAL_LO 8'h10

// Write offsets
`define TLS_WR_CONFIG        8'h09
`define TLS_WR_LOCAL_HIGH    8'h0b
`define TLS_WR_LOCAL_LOW     8'h0c
`define TLS_WR_REM_HIGH_HI   8'h0d
`define TLS_WR_REM_LOW_HI    8'h0e
`define TLS_WR_ONE_SHOT      8'h0f

// Shared read/write offsets
`define TLS_OFFSET_UPPER     8'h11
`define TLS_OFFSET_LOWER     8'h12
`define TLS_REM_HIGH_LO      8'h13
`define TLS_REM_LOW_LO       8'h14
`define TLS_REM_TRIP_LIM     8'h19
`define TLS_LOC_TRIP_LIM     8'h20
`define TLS_TRIP_HYST        8'h21

// Reset values
`define TLS_RST_LOCAL_HIGH   8'h55
`define TLS_RST_LOCAL_LOW    8'h00
`define TLS_RST_REM_HIGH     8'h55
`define TLS_RST_REM_LOW      8'h00
`define TLS_RST_REM_LO_BYTE  8'h00
`define TLS_RST_REM_TRIP     8'h6c
`define TLS_RST_LOC_TRIP     8'h55
`define TLS_RST_HYST         8'h0a
`define TLS_RST_OFFSET       8'h00
`define TLS_RST_CONFIG       8'h00

// Configuration bit positions
`define TLS_CFG_MASK_BIT     7
`define TLS_CFG_STANDBY_BIT  6
`define TLS_CFG_PIN6_BIT     5
`define TLS_CFG_RANGE_BIT    2

// Status bit positions
`define TLS_ST_BUSY          7
`define TLS_ST_LOC_OVER      6
`define TLS_ST_LOC_UNDER     5
`define TLS_ST_REM_OVER      4
`define TLS_ST_REM_UNDER     3
`define TLS_ST_OPEN          2
`define TLS_ST_REM_TRIP      1
`define TLS_ST_LOC_TRIP      0

`endif

// [hdl/tls_trip_cell.v]
// Comparator trip channel with hysteresis for one temperature channel.
// Assumes value, limit and hysteresis are stable bytes on the same clock.
`timescale 1ns/10ps
module tls_trip_cell (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire [7:0] value_in,
  input wire [7:0] limit_in,
  input wire [7:0] hyst_in,
  output wire trip_out
);

  reg trip_q;
  reg trip_d;
  wire [8:0] diff;
  wire [7:0] release_thr;

  // Hysteresis larger than the limit releases only at the bottom of scale
  assign diff = {1'b0, limit_in} - {1'b0, hyst_in};
  assign release_thr = diff[8] ? 8'h00 : diff[7:0];

  always @*
  begin
    trip_d = trip_q;
    if (value_in > limit_in)
    begin
      trip_d = 1'b1;
    end
    else if (value_in <= release_thr)
    begin
      trip_d = 1'b0;
    end
  end

  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      trip_q <= 1'b0;
    end
    else
    begin
      trip_q <= trip_d;
    end
  end

  assign trip_out = trip_q;

endmodule // tls_trip_cell

// [hdl/tls_top.v]
// Limit comparison, status flags and alarm/trip outputs of a two-channel monitor.
// Assumes a protocol engine issuing one-cycle register read/write pulses on clk.
// How it works
// - Every limit register is writable and readable; remote limits have two bytes.
// - Alarm mode flags a high violation only when reading is strictly above limit.
// - A reading equal to or below the low limit sets the low flag.
// - Fan trip output goes low when local or remote trip limit is exceeded.
// - In second-trip mode pin 6 goes low when either high limit is exceeded.
// - One hysteresis byte at 0x21, reset to 10, serves both trip channels.
// - Status byte at 0x02 is read-only; bit 7 shows conversion busy.
// - Status bits 6..0 map local/remote over, under, open, remote and local trip.
// - In alarm mode any of status bits 6..2 sets the alarm latch.
// - Status read clears bits 6..2 only where their cause has gone.
// - Alarm latch clears only on alert response with causes gone and flags clear.
// - Trip bits 1 and 0 hold fan trip low and self-clear when back in limits.
// - Trip releases only at trip limit minus hysteresis.
// - Second-trip output uses only bits 6 and 4 and releases at the high limit, with no hysteresis.
// - Flags latch until status read or reset; in second-trip mode only open latches.
// - Remote offset is 10-bit two's complement: 0x11 upper byte, 0x12 top two bits.
// - Signed offset in quarter degrees is added to every remote result.
// - Offset resets to zero so remote results pass unchanged.
// - Write to 0x0F in standby runs one conversion; data is discarded.
// - Config bit 5 selects pin 6 as alarm output or second trip output.
// - Config bit 7 masks the alarm output, only in alarm mode.
// - Config bit 6 selects standby; bus and both outputs stay active.
`timescale 1ns/10ps
`include "tls_map.vh"
module tls_top (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output wire [7:0] reg_rdata_out,
  input wire alert_ack_in,
  output wire alarm_pending_out,
  input wire conv_tick_in,
  output wire conv_start_out,
  input wire adc_done_in,
  input wire [7:0] adc_local_in,
  input wire [9:0] adc_remote_in,
  input wire adc_open_in,
  output wire range_ext_out,
  output wire standby_out,
  output wire fan_trip_n_out,
  output wire pin6_n_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;

  reg rst_meta_q;
  reg rst_sync_q;
  wire rst_n;

  reg [7:0] cfg_q;
  reg [7:0] loc_high_q;
  reg [7:0] loc_low_q;
  reg [7:0] rem_high_hi_q;
  reg [7:0] rem_high_lo_q;
  reg [7:0] rem_low_hi_q;
  reg [7:0] rem_low_lo_q;
  reg [7:0] rem_trip_q;
  reg [7:0] loc_trip_q;
  reg [7:0] hyst_q;
  reg [7:0] off_hi_q;
  reg [7:0] off_lo_q;

  reg [7:0] loc_val_q;
  reg [9:0] rem_val_q;
  reg open_q;
  reg state_q;
  reg state_d;
  reg one_shot_q;
  reg alarm_q;
  reg [6:2] flag_q;
  reg [7:0] rdata_q;
  reg [7:0] rdata_d;

  wire second_trip_mode;
  wire standby;
  wire rd_status;
  wire [9:0] rem_high_lim;
  wire [9:0] rem_low_lim;
  wire [9:0] offset_val;
  wire [11:0] rem_sum;
  wire [9:0] rem_adj;
  wire [6:2] cond;
  wire [6:2] flag_d;
  wire loc_trip_flag;
  wire rem_trip_flag;
  wire [7:0] status;
  wire start_conv;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  assign second_trip_mode = cfg_q[`TLS_CFG_PIN6_BIT];
  assign standby = cfg_q[`TLS_CFG_STANDBY_BIT];
  assign rd_status = reg_rd_in && (reg_addr_in == `TLS_RD_STATUS);

  // Register writes
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_q <= `TLS_RST_CONFIG;
      loc_high_q <= `TLS_RST_LOCAL_HIGH;
      loc_low_q <= `TLS_RST_LOCAL_LOW;
      rem_high_hi_q <= `TLS_RST_REM_HIGH;
      rem_high_lo_q <= `TLS_RST_REM_LO_BYTE;
      rem_low_hi_q <= `TLS_RST_REM_LOW;
      rem_low_lo_q <= `TLS_RST_REM_LO_BYTE;
      rem_trip_q <= `TLS_RST_REM_TRIP;
      loc_trip_q <= `TLS_RST_LOC_TRIP;
      hyst_q <= `TLS_RST_HYST;
      off_hi_q <= `TLS_RST_OFFSET;
      off_lo_q <= `TLS_RST_OFFSET;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `TLS_WR_CONFIG)
      begin
        // Reserved bits are not stored and read as zero
        cfg_q <= reg_wdata_in & 8'he4;
      end
      else if (reg_addr_in == `TLS_WR_LOCAL_HIGH)
      begin
        loc_high_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_WR_LOCAL_LOW)
      begin
        loc_low_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_WR_REM_HIGH_HI)
      begin
        rem_high_hi_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_REM_HIGH_LO)
      begin
        rem_high_lo_q <= {reg_wdata_in[7:6], 6'h00};
      end
      else if (reg_addr_in == `TLS_WR_REM_LOW_HI)
      begin
        rem_low_hi_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_REM_LOW_LO)
      begin
        rem_low_lo_q <= {reg_wdata_in[7:6], 6'h00};
      end
      else if (reg_addr_in == `TLS_REM_TRIP_LIM)
      begin
        rem_trip_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_LOC_TRIP_LIM)
      begin
        loc_trip_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_TRIP_HYST)
      begin
        hyst_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_OFFSET_UPPER)
      begin
        off_hi_q <= reg_wdata_in;
      end
      else if (reg_addr_in == `TLS_OFFSET_LOWER)
      begin
        off_lo_q <= {reg_wdata_in[7:6], 6'h00};
      end
    end
  end

  // Remote offset: sign-extended sum, clamped to the 10-bit scale
  assign offset_val = {off_hi_q, off_lo_q[7:6]};
  assign rem_sum = {2'b00, adc_remote_in} + {{2{offset_val[9]}}, offset_val};
  assign rem_adj = rem_sum[11] ? 10'h000 : (rem_sum[10] ? 10'h3ff : rem_sum[9:0]);

  // One-shot request waits out any conversion already running
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      one_shot_q <= 1'b0;
    end
    else if (reg_wr_in && (reg_addr_in == `TLS_WR_ONE_SHOT) && standby)
    begin
      one_shot_q <= 1'b1;
    end
    else if (start_conv)
    begin
      one_shot_q <= 1'b0;
    end
  end

  assign start_conv = (state_q == ST_IDLE) &&
    ((!standby && conv_tick_in) || one_shot_q);

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_conv)
        begin
          state_d = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (adc_done_in)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      loc_val_q <= 8'h00;
      rem_val_q <= 10'h000;
      open_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if ((state_q == ST_CONV) && adc_done_in)
      begin
        loc_val_q <= adc_local_in;
        rem_val_q <= rem_adj;
        open_q <= adc_open_in;
      end
    end
  end

  // Limits compare in the measurement format, whatever the range setting
  assign rem_high_lim = {rem_high_hi_q, rem_high_lo_q[7:6]};
  assign rem_low_lim = {rem_low_hi_q, rem_low_lo_q[7:6]};
  assign cond[`TLS_ST_LOC_OVER] = loc_val_q > loc_high_q;
  assign cond[`TLS_ST_LOC_UNDER] = loc_val_q <= loc_low_q;
  assign cond[`TLS_ST_REM_OVER] = rem_val_q > rem_high_lim;
  assign cond[`TLS_ST_REM_UNDER] = rem_val_q <= rem_low_lim;
  assign cond[`TLS_ST_OPEN] = open_q;

  // Latched flags: a live cause beats a clearing read
  genvar gi;
  generate
    for (gi = 2; gi <= 6; gi = gi + 1)
    begin : g_flag
      if (gi == `TLS_ST_OPEN)
      begin : g_open
        assign flag_d[gi] = cond[gi] | (flag_q[gi] & ~rd_status);
      end
      else
      begin : g_lim
        assign flag_d[gi] = second_trip_mode ? cond[gi] :
          (cond[gi] | (flag_q[gi] & ~rd_status));
      end
    end
  endgenerate

  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 5'h00;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  tls_trip_cell u_loc_trip (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .value_in(loc_val_q),
    .limit_in(loc_trip_q),
    .hyst_in(hyst_q),
    .trip_out(loc_trip_flag)
  );

  // Remote trip limit is whole degrees, so the fraction is dropped
  tls_trip_cell u_rem_trip (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .value_in(rem_val_q[9:2]),
    .limit_in(rem_trip_q),
    .hyst_in(hyst_q),
    .trip_out(rem_trip_flag)
  );

  assign status = {(state_q == ST_CONV), flag_q, rem_trip_flag, loc_trip_flag};

  // Alarm latch survives status reads; only a serviced alert clears it
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alarm_q <= 1'b0;
    end
    else if (!second_trip_mode && (|flag_q))
    begin
      alarm_q <= 1'b1;
    end
    else if (alert_ack_in && !(|cond) && !(|flag_q))
    begin
      alarm_q <= 1'b0;
    end
  end

  assign fan_trip_n_out = ~(loc_trip_flag | rem_trip_flag);
  assign pin6_n_out = second_trip_mode ?
    ~(flag_q[`TLS_ST_LOC_OVER] | flag_q[`TLS_ST_REM_OVER]) :
    ~(alarm_q & ~cfg_q[`TLS_CFG_MASK_BIT]);
  assign alarm_pending_out = alarm_q;
  assign conv_start_out = start_conv;
  assign range_ext_out = cfg_q[`TLS_CFG_RANGE_BIT];
  assign standby_out = standby;

  // Read mux; unmapped offsets read zero
  always @*
  begin
    rdata_d = 8'h00;
    if (reg_addr_in == `TLS_RD_LOCAL_VAL)
    begin
      rdata_d = loc_val_q;
    end
    else if (reg_addr_in == `TLS_RD_REMOTE_VAL_HI)
    begin
      rdata_d = rem_val_q[9:2];
    end
    else if (reg_addr_in == `TLS_RD_REMOTE_VAL_LO)
    begin
      rdata_d = {rem_val_q[1:0], 6'h00};
    end
    else if (reg_addr_in == `TLS_RD_STATUS)
    begin
      rdata_d = status;
    end
    else if (reg_addr_in == `TLS_RD_CONFIG)
    begin
      rdata_d = cfg_q;
    end
    else if (reg_addr_in == `TLS_RD_LOCAL_HIGH)
    begin
      rdata_d = loc_high_q;
    end
    else if (reg_addr_in == `TLS_RD_LOCAL_LOW)
    begin
      rdata_d = loc_low_q;
    end
    else if (reg_addr_in == `TLS_RD_REM_HIGH_HI)
    begin
      rdata_d = rem_high_hi_q;
    end
    else if (reg_addr_in == `TLS_RD_REM_LOW_HI)
    begin
      rdata_d = rem_low_hi_q;
    end
    else if (reg_addr_in == `TLS_REM_HIGH_LO)
    begin
      rdata_d = rem_high_lo_q;
    end
    else if (reg_addr_in == `TLS_REM_LOW_LO)
    begin
      rdata_d = rem_low_lo_q;
    end
    else if (reg_addr_in == `TLS_REM_TRIP_LIM)
    begin
      rdata_d = rem_trip_q;
    end
    else if (reg_addr_in == `TLS_LOC_TRIP_LIM)
    begin
      rdata_d = loc_trip_q;
    end
    else if (reg_addr_in == `TLS_TRIP_HYST)
    begin
      rdata_d = hyst_q;
    end
    else if (reg_addr_in == `TLS_OFFSET_UPPER)
    begin
      rdata_d = off_hi_q;
    end
    else if (reg_addr_in == `TLS_OFFSET_LOWER)
    begin
      rdata_d = off_lo_q;
    end
  end

  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (reg_rd_in)
    begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule // tls_top

// [verif/tls_top_properties.sv]
// Port checker for tls_top.
// Assumes one clock domain; bound onto every tls_top instance.
`timescale 1ns/10ps
module tls_top_props (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire [7:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire alert_ack_in,
  input wire alarm_pending_out,
  input wire conv_tick_in,
  input wire conv_start_out,
  input wire adc_done_in,
  input wire range_ext_out,
  input wire standby_out,
  input wire pin6_n_out
);
  reg [7:0] cfg_q;
  reg busy_q;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!arst_n_in);
  // Shadow of config writes and conversion state
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg_q <= 8'h00;
      busy_q <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == 8'h09)
        cfg_q <= reg_wdata_in & 8'he4;
      if (conv_start_out)
        busy_q <= 1'b1;
      else if (adc_done_in)
        busy_q <= 1'b0;
    end
  end
  mode_pins_a: assert property (standby_out == cfg_q[6] && range_ext_out == cfg_q[2])
    else $error("mode outputs differ from config");
  alarm_drive_a: assert property (!cfg_q[5] && !cfg_q[7] |-> pin6_n_out == !alarm_pending_out)
    else $error("alarm pin does not follow latch");
  alarm_mask_a: assert property (!cfg_q[5] && cfg_q[7] |-> pin6_n_out)
    else $error("masked alarm pin driven low");
  alarm_hold_a: assert property (alarm_pending_out && !alert_ack_in |=> alarm_pending_out)
    else $error("alarm latch cleared without alert response");
  one_shot_a: assert property (reg_wr_in && reg_addr_in == 8'h0f && standby_out && !busy_q
    && !conv_start_out |=> conv_start_out)
    else $error("one-shot write did not start a conversion");
  no_overlap_a: assert property (conv_start_out |-> !busy_q)
    else $error("conversion started while busy");
  run_tick_a: assert property (conv_tick_in && !standby_out && !busy_q |-> conv_start_out)
    else $error("tick in run mode did not start a conversion");
  rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data changed without a read");
  busy_bit_a: assert property (reg_rd_in && reg_addr_in == 8'h02 && busy_q && !adc_done_in
    |=> reg_rdata_out[7])
    else $error("status busy bit low during conversion");
  write_only_a: assert property (reg_rd_in && reg_addr_in == 8'h0f |=> reg_rdata_out == 8'h00)
    else $error("one-shot address returned data");
endmodule // tls_top_props

bind tls_top tls_top_props i_tls_top_props (.*);

// [verif/tls_host_model.sv]
// Host side model: one-cycle register strobes and alert response.
// Assumes the register port timing of tls_top.
`timescale 1ns/10ps
module tls_host_model (
  input wire clk_sys_in,
  output reg [7:0] reg_addr_out,
  output reg reg_wr_out,
  output reg [7:0] reg_wdata_out,
  output reg reg_rd_out,
  output reg alert_ack_out,
  input wire [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
    alert_ack_out = 1'b0;
  end
  task automatic wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys_in) #1;
      reg_addr_out = a;
      reg_wdata_out = d;
      reg_wr_out = 1'b1;
      @(posedge clk_sys_in) #1;
      reg_wr_out = 1'b0;
      // Released data never keeps the stale value
      reg_wdata_out = ~d;
    end
  endtask
  task automatic rd_reg(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk_sys_in) #1;
      reg_addr_out = a;
      reg_rd_out = 1'b1;
      @(posedge clk_sys_in) #1;
      reg_rd_out = 1'b0;
      d = reg_rdata_in;
    end
  endtask
  // Latch release lands one edge after the response
  task automatic ack_alert;
    begin
      @(posedge clk_sys_in) #1;
      alert_ack_out = 1'b1;
      @(posedge clk_sys_in) #1;
      alert_ack_out = 1'b0;
      @(posedge clk_sys_in) #1;
    end
  endtask
endmodule // tls_host_model

// [verif/tls_top_bench.sv]
// Self-checking bench for tls_top: register calls with expected values.
// Assumes the host model owns the register port; the ADC answers here.
`timescale 1ns/10ps
module tls_top_bench;
  reg clk_sys_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg conv_tick_in = 1'b0;
  reg adc_done_in = 1'b0;
  reg adc_open_in = 1'b0;
  reg [7:0] adc_local_in = 8'h20;
  reg [9:0] adc_remote_in = 10'h078;
  wire [7:0] reg_addr, reg_wdata, rdata;
  wire reg_wr, reg_rd, alert_ack, alarm_pending, conv_start;
  wire range_ext, standby, fan_trip_n, pin6_n;
  integer error_cnt = 0;
  integer num_checks = 0;
  integer cyc = 0;
  reg [7:0] rv;
  always #2 clk_sys_in = ~clk_sys_in;
  tls_host_model i_tls_host_model (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr),
    .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd),
    .alert_ack_out(alert_ack), .reg_rdata_in(rdata));
  tls_top i_tls_top (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .alert_ack_in(alert_ack), .alarm_pending_out(alarm_pending), .conv_tick_in(conv_tick_in),
    .conv_start_out(conv_start), .adc_done_in(adc_done_in), .adc_local_in(adc_local_in),
    .adc_remote_in(adc_remote_in), .adc_open_in(adc_open_in), .range_ext_out(range_ext),
    .standby_out(standby), .fan_trip_n_out(fan_trip_n), .pin6_n_out(pin6_n));
  // ADC answers three cycles after each start
  always @(posedge clk_sys_in)
    if (conv_start)
    begin
      repeat (3) @(posedge clk_sys_in);
      #1 adc_done_in = 1'b1;
      @(posedge clk_sys_in) #1;
      adc_done_in = 1'b0;
    end
  always @(posedge clk_sys_in)
  begin
    cyc = cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  function [7:0] b(input x);
    b = {7'h00, x};
  endfunction
  task check(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rdc(input [7:0] a, input [7:0] exp);
    begin
      i_tls_host_model.rd_reg(a, rv);
      check(rv, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    i_tls_host_model.wr_reg(a, d);
  endtask
  // One-shot conversion; the written byte is irrelevant
  task conv(input [7:0] l, input o);
    begin
      adc_local_in = l;
      adc_open_in = o;
      wr(8'h0f, 8'ha5);
      check(b(conv_start), 8'h01);
      // Result, then flag, then alarm latch: each takes one more edge
      repeat (8) @(posedge clk_sys_in);
      #1;
    end
  endtask
  task end_of_test;
    begin
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk_sys_in);
    #1 arst_n_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    rdc(8'h21, 8'h0a);
    rdc(8'h11, 8'h00);
    rdc(8'h12, 8'h00);
    rdc(8'h19, 8'h6c);
    rdc(8'h30, 8'h00);
    rdc(8'h0f, 8'h00);
    wr(8'h0b, 8'h50);
    rdc(8'h05, 8'h50);
    wr(8'h13, 8'hff);
    rdc(8'h13, 8'hc0);
    wr(8'h21, 8'h05);
    rdc(8'h21, 8'h05);
    // Run-mode conversion on in-limit values, then clear power-up flags
    conv_tick_in = 1'b1;
    @(posedge clk_sys_in) #1;
    conv_tick_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    i_tls_host_model.rd_reg(8'h02, rv);
    rdc(8'h02, 8'h00);
    i_tls_host_model.ack_alert;
    check(b(alarm_pending), 8'h00);
    wr(8'h09, 8'h40);
    check(b(standby), 8'h01);
    @(posedge clk_sys_in) #1;
    conv_tick_in = 1'b1;
    @(posedge clk_sys_in) #1;
    conv_tick_in = 1'b0;
    rdc(8'h02, 8'h00);
    wr(8'h0f, 8'h00);
    rdc(8'h02, 8'h80);
    repeat (6) @(posedge clk_sys_in);
    conv(8'h50, 1'b0);
    rdc(8'h02, 8'h00);
    conv(8'h51, 1'b0);
    check(b(pin6_n), 8'h00);
    rdc(8'h02, 8'h40);
    rdc(8'h02, 8'h40);
    i_tls_host_model.ack_alert;
    check(b(alarm_pending), 8'h01);
    wr(8'h09, 8'hc0);
    check(b(pin6_n), 8'h01);
    wr(8'h09, 8'h40);
    conv(8'h20, 1'b0);
    rdc(8'h02, 8'h40);
    rdc(8'h02, 8'h00);
    check(b(alarm_pending), 8'h01);
    i_tls_host_model.ack_alert;
    check(b(pin6_n), 8'h01);
    conv(8'h00, 1'b1);
    rdc(8'h02, 8'h24);
    conv(8'h20, 1'b0);
    i_tls_host_model.rd_reg(8'h02, rv);
    i_tls_host_model.ack_alert;
    // Offset of -3.25 degrees: 30 becomes 26.75
    wr(8'h11, 8'hfc);
    wr(8'h12, 8'hff);
    rdc(8'h12, 8'hc0);
    conv(8'h20, 1'b0);
    rdc(8'h01, 8'h1a);
    rdc(8'h10, 8'hc0);
    // Second-trip mode; mask bit must have no effect here
    wr(8'h09, 8'he0);
    conv(8'h51, 1'b0);
    check(b(pin6_n), 8'h00);
    conv(8'h00, 1'b0);
    check(b(pin6_n), 8'h01);
    conv(8'h56, 1'b0);
    check(b(fan_trip_n), 8'h00);
    conv(8'h51, 1'b0);
    check(b(fan_trip_n), 8'h00);
    conv(8'h50, 1'b0);
    check(b(fan_trip_n), 8'h01);
    rdc(8'h02, 8'h00);
    wr(8'h09, 8'h44);
    check(b(range_ext), 8'h01);
    wr(8'h0b, 8'h90);
    rdc(8'h05, 8'h90);
    end_of_test;
  end
endmodule // tls_top_bench
